// *** pkg/smc_pkg.sv ***
// Package of constants and carrier types for the snoop match combiner.
package smc_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int SMC_NUM_STAGES  = 4;
    localparam int SMC_NUM_PARSERS = 4;
    localparam int SMC_ADDR_W      = 12;
    localparam int SMC_DATA_W      = 32;
    localparam int SMC_CNT_W       = 16;
    localparam int SMC_FIRST_INDEX = 4;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] SMC_STAGE_BASE   = 12'h0F0;
    localparam logic [11:0] SMC_STAGE_STRIDE = 12'h004;
    localparam logic [11:0] SMC_STATUS_ADDR  = 12'h0E0;
    localparam logic [11:0] SMC_COUNT_ADDR   = 12'h0E4;

    // ****************************************
    // Stage register fields and masks
    // ****************************************
    typedef struct packed {
        logic [9:0] rsvd_hi;
        logic [1:0] snoop_action;
        logic [1:0] rsvd_mid;
        logic       result_invert;
        logic       operation;
        logic       rsvd_b15;
        logic       use_stage2_result;
        logic       use_stage1_result;
        logic       use_stage0_result;
        logic [3:0] select_match;
        logic [3:0] rsvd_lo;
        logic [3:0] not_input;
    } smc_stage_cfg_s;

    localparam logic [31:0] SMC_CFG_RESET       = 32'h0000_0000;
    localparam logic [31:0] SMC_WMASK_COMMON    = 32'h0003_0F0F;
    localparam logic [31:0] SMC_WMASK_USE_S0    = 32'h0000_1000;
    localparam logic [31:0] SMC_WMASK_USE_S1    = 32'h0000_2000;
    localparam logic [31:0] SMC_WMASK_USE_S2    = 32'h0000_4000;
    localparam logic [31:0] SMC_WMASK_SNOOP     = 32'h0030_0000;
    localparam logic [31:0] SMC_WMASK [SMC_NUM_STAGES] = '{
        SMC_WMASK_COMMON,
        SMC_WMASK_COMMON | SMC_WMASK_USE_S0,
        SMC_WMASK_COMMON | SMC_WMASK_USE_S0 | SMC_WMASK_USE_S1,
        SMC_WMASK_COMMON | SMC_WMASK_USE_S0 | SMC_WMASK_USE_S1
            | SMC_WMASK_USE_S2 | SMC_WMASK_SNOOP
    };

    // ****************************************
    // Snoop actions
    // ****************************************
    localparam logic [1:0] SMC_ACT_FORWARD   = 2'h0;
    localparam logic [1:0] SMC_ACT_MGMT_ONLY = 2'h1;
    localparam logic [1:0] SMC_ACT_MGMT_COPY = 2'h2;
    localparam logic [1:0] SMC_ACT_DISCARD   = 2'h3;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [3:0] valid;
        logic [3:0] match;
    } smc_parsers_s;

    typedef struct packed {
        logic       match;
        logic [1:0] action;
    } smc_block_res_s;

    typedef struct packed {
        logic [3:0] stage_out;
        logic       final_match;
        logic       blk0_match;
        logic [1:0] action;
    } smc_result_s;

endpackage

// *** design/smc_stage.sv ***
// One combining stage of the snoop match combiner.
`timescale 1ns/1ps
`default_nettype none
module smc_stage
    import smc_pkg::*;
#(
    parameter int STAGE_IDX = 0
) (
    // Configuration
    input  wire smc_stage_cfg_s i_cfg,
    // Match inputs
    input  wire logic [3:0]     i_match,
    input  wire logic [2:0]     i_prev,
    // Result
    output logic                o_result
);
    logic [6:0] sel;
    logic [6:0] val;
    logic       and_r;
    logic       or_r;

    always_comb begin
        sel[3:0] = i_cfg.select_match;
        sel[4]   = i_cfg.use_stage0_result && (STAGE_IDX >= 1);
        sel[5]   = i_cfg.use_stage1_result && (STAGE_IDX >= 2);
        sel[6]   = i_cfg.use_stage2_result && (STAGE_IDX == 3);
        val      = {i_prev, i_match ^ i_cfg.not_input};
        and_r    = &(val | ~sel);
        or_r     = |(val & sel);
        o_result = (i_cfg.operation ? or_r : and_r) ^ i_cfg.result_invert;
    end
endmodule // smc_stage
`default_nettype wire

// *** design/smc_action_merge.sv ***
// Merge of the two combining blocks' snoop actions.
`timescale 1ns/1ps
`default_nettype none
module smc_action_merge
    import smc_pkg::*;
(
    // Block results
    input  wire smc_block_res_s i_blk0,
    input  wire smc_block_res_s i_blk1,
    // Chosen action
    output logic [1:0]          o_action
);
    always_comb begin
        o_action = SMC_ACT_FORWARD;
        if (i_blk0.match && i_blk1.match) begin
            // Lower code wins on a conflict.
            o_action = (i_blk0.action < i_blk1.action) ? i_blk0.action : i_blk1.action;
        end else if (i_blk0.match) begin
            o_action = i_blk0.action;
        end else if (i_blk1.match) begin
            o_action = i_blk1.action;
        end
    end
endmodule // smc_action_merge
`default_nettype wire

// *** design/smc_top.sv ***
// Snoop match combiner: second block of cascaded stages, registers and action.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Four stage registers, indices 4 to 7, configure stages 0 to 3.
// - Action 00 forwards, 01 management only, 10 adds copy, 11 discards.
// - Both blocks matching with different actions: lower action code wins.
// - Action bits 21:20 exist only in the final stage register.
// - Result inversion bit inverts the stage output when set.
// - Operation bit picks AND (0) or OR (1) of selected inputs.
// - Only stage 3 honours the stage 2 result selection.
// - Only stages 2 and 3 honour the stage 1 result selection.
// - Only stages 1 to 3 honour the stage 0 result selection.
// - Bits 11:8 select parsers 0 to 3 into the stage.
// - Bits 3:0 invert parser match inputs before use.
// - An invalid parser is masked to no match before the bits 3:0 inversion, so with its invert bit set the stage sees a match.
module smc_top
    import smc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    // Register port
    input  wire logic [SMC_ADDR_W-1:0] i_reg_addr,
    input  wire logic [SMC_DATA_W-1:0] i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic [SMC_DATA_W-1:0]      o_reg_rdata,
    // Frame evaluation request
    input  wire logic                  i_frame_valid,
    input  wire smc_parsers_s          i_parsers,
    input  wire smc_block_res_s        i_blk0,
    // Frame decision
    output logic                       o_result_valid,
    output logic [3:0]                 o_stage_out,
    output logic                       o_final_match,
    output logic [1:0]                 o_action
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        smc_stage_cfg_s [SMC_NUM_STAGES-1:0] cfg;
        logic [SMC_DATA_W-1:0]               rdata;
        logic                                res_valid;
        smc_result_s                         res;
        logic [SMC_CNT_W-1:0]                frame_cnt;
        logic [SMC_CNT_W-1:0]                match_cnt;
    } smc_state_s;

    smc_state_s q;
    smc_state_s d;

    // ****************************************
    // Combining stages
    // ****************************************
    logic [3:0]     parser_m;
    logic [3:0]     stage_out;
    logic [1:0]     final_action;
    smc_block_res_s blk1;

    assign parser_m = i_parsers.match & i_parsers.valid;

    genvar gi;
    generate
        for (gi = 0; gi < SMC_NUM_STAGES; gi++) begin : g_stage
            logic [2:0] prev;
            // Later stages see only earlier outputs, so the chain never loops.
            // The first stage gets no reference to the stage vector at all.
            if (gi == 0) begin : g_first
                assign prev = 3'h0;
            end else begin : g_later
                assign prev = 3'(stage_out[gi-1:0]);
            end
            smc_stage #(
                .STAGE_IDX (gi)
            ) u_stage (
                .i_cfg    (q.cfg[gi]),
                .i_match  (parser_m),
                .i_prev   (prev),
                .o_result (stage_out[gi])
            );
        end
    endgenerate

    assign blk1.match  = stage_out[SMC_NUM_STAGES-1];
    assign blk1.action = q.cfg[SMC_NUM_STAGES-1].snoop_action;

    smc_action_merge u_merge (
        .i_blk0   (i_blk0),
        .i_blk1   (blk1),
        .o_action (final_action)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d           = q;
        d.rdata     = '0;
        d.res_valid = i_frame_valid;
        for (int s = 0; s < SMC_NUM_STAGES; s++) begin
            if (i_reg_addr == SMC_STAGE_BASE + 12'(s) * SMC_STAGE_STRIDE) begin
                if (i_reg_wr) begin
                    // Reserved and absent bits are dropped, so they read as zero.
                    d.cfg[s] = (q.cfg[s] & ~SMC_WMASK[s]) | (i_reg_wdata & SMC_WMASK[s]);
                end
                if (i_reg_rd) begin
                    d.rdata = q.cfg[s];
                end
            end
        end
        if (i_reg_rd && i_reg_addr == SMC_STATUS_ADDR) begin
            d.rdata = 32'(q.res);
        end
        if (i_reg_addr == SMC_COUNT_ADDR) begin
            if (i_reg_rd) begin
                d.rdata = {q.match_cnt, q.frame_cnt};
            end
            if (i_reg_wr) begin
                d.frame_cnt = '0;
                d.match_cnt = '0;
            end
        end
        if (i_frame_valid) begin
            // A frame in the clearing cycle still counts: the set wins.
            d.frame_cnt       = d.frame_cnt + 16'h0001;
            d.res.stage_out   = stage_out;
            d.res.final_match = stage_out[SMC_NUM_STAGES-1];
            d.res.blk0_match  = i_blk0.match;
            d.res.action      = final_action;
            if (stage_out[SMC_NUM_STAGES-1]) begin
                d.match_cnt = d.match_cnt + 16'h0001;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_reg_rdata    = q.rdata;
    assign o_result_valid = q.res_valid;
    assign o_stage_out    = q.res.stage_out;
    assign o_final_match  = q.res.final_match;
    assign o_action       = q.res.action;

endmodule // smc_top
`default_nettype wire

// *** dv/smc_top_asserts.sv ***
// Port checker of the snoop match combiner.
`timescale 1ns/1ps
`default_nettype none
module smc_top_asserts
    import smc_pkg::*;
(
    // Clock, reset and register port
    input wire logic                  i_ref_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_reg_rd,
    input wire logic [SMC_DATA_W-1:0] o_reg_rdata,
    // Frame path
    input wire logic                  i_frame_valid,
    input wire smc_block_res_s        i_blk0,
    input wire logic                  o_result_valid,
    input wire logic [3:0]            o_stage_out,
    input wire logic                  o_final_match,
    input wire logic [1:0]            o_action
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_result_next: assert property (i_frame_valid |=> o_result_valid)
        else $error("no decision after frame");
    a_result_only: assert property (!i_frame_valid |=> !o_result_valid)
        else $error("decision without frame");
    a_rdata_quiet: assert property (!i_reg_rd |=> o_reg_rdata == '0)
        else $error("read data outside read");
    a_decision_hold: assert property (!i_frame_valid
        |=> $stable({o_stage_out, o_final_match, o_action}))
        else $error("decision changed without frame");
    a_final_stage: assert property (o_final_match == o_stage_out[3])
        else $error("final match differs from last stage");
    a_idle_forward: assert property (o_result_valid && !o_final_match && !$past(i_blk0.match)
        |-> o_action == 2'h0) else $error("action without match");
    a_lower_wins: assert property (o_result_valid && $past(i_blk0.match)
        |-> o_action <= $past(i_blk0.action)) else $error("higher action chosen");
    a_first_alone: assert property (o_result_valid && !o_final_match && $past(i_blk0.match)
        |-> o_action == $past(i_blk0.action)) else $error("first block action lost");
endmodule // smc_top_asserts
bind smc_top smc_top_asserts smc_top_asserts_i (.i_ref_clk, .i_nrst, .i_reg_rd, .o_reg_rdata,
    .i_frame_valid, .i_blk0, .o_result_valid, .o_stage_out, .o_final_match, .o_action);
`default_nettype wire

// *** dv/smc_frame_src.sv ***
// Model of the block's parsers and of the first combining block.
`timescale 1ns/1ps
`default_nettype none
module smc_frame_src
    import smc_pkg::*;
#(
    parameter int SEED = 32'h158EC22A
) (
    // Clock and control
    input  wire logic      i_ref_clk,
    input  wire logic      i_en,
    // Frame towards the combiner
    output smc_parsers_s   o_parsers,
    output smc_block_res_s o_blk0,
    output logic           o_frame_valid
);
    int seed = SEED;
    initial begin
        o_frame_valid = 1'b0;
        o_parsers = '0;
        o_blk0 = '0;
    end
    // Match bits stay random on invalid parsers, so the valid masking is exercised.
    always @(posedge i_ref_clk) begin
        if (i_en) begin
            o_frame_valid <= ($random(seed) & 3) != 0;
            o_parsers     <= 8'($random(seed));
            o_blk0        <= 3'($random(seed));
        end else begin
            o_frame_valid <= 1'b0;
            o_parsers     <= ~o_parsers;
            o_blk0        <= ~o_blk0;
        end
    end
endmodule // smc_frame_src
`default_nettype wire

// *** dv/smc_top_tb.sv ***
// Self-checking bench of the snoop match combiner.
`timescale 1ns/1ps
`default_nettype none
`define SMC_CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module smc_top_tb import smc_pkg::*;;
    logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, en = 1'b0;
    logic [11:0] i_reg_addr = '0;
    logic [31:0] i_reg_wdata = '0, o_reg_rdata;
    logic i_frame_valid, o_result_valid, o_final_match;
    logic [3:0] o_stage_out;
    logic [1:0] o_action;
    logic [6:0] e_q;
    logic [6:0] e_n;
    logic [7:0] stat = '0;
    int n_frm = 0, n_mat = 0;
    smc_parsers_s i_parsers;
    smc_block_res_s i_blk0;
    int errors = 0, n_checks = 0, seed = 32'h158EC22A;
    logic [31:0] cfg [4] = '{default: '0};
    logic [6:0] expq [$];
    always #5 i_ref_clk = ~i_ref_clk;
    smc_top smc_top_i (.i_ref_clk, .i_nrst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
        .o_reg_rdata, .i_frame_valid, .i_parsers, .i_blk0, .o_result_valid, .o_stage_out,
        .o_final_match, .o_action);
    smc_frame_src smc_frame_src_i (.i_ref_clk, .i_en(en), .o_parsers(i_parsers),
        .o_blk0(i_blk0), .o_frame_valid(i_frame_valid));
    // Reference decision, written from the stage and action rules.
    function automatic logic [6:0] model(smc_parsers_s p, smc_block_res_s b);
        logic [3:0] s;
        logic v;
        logic [1:0] a;
        for (int k = 0; k < 4; k++) begin
            s[k] = !cfg[k][16];
            for (int j = 0; j < 7; j++) begin
                if (j < 4) v = (p.match[j] & p.valid[j]) ^ cfg[k][j];
                else v = s[j-4];
                if (cfg[k][8+j] && (j < 4 || j - 4 < k)) s[k] = cfg[k][16] ? s[k] | v : s[k] & v;
            end
            s[k] = s[k] ^ cfg[k][17];
        end
        a = cfg[3][21:20];
        if (!s[3]) a = b.match ? b.action : 2'h0;
        else if (b.match && b.action < a) a = b.action;
        return {s, s[3], a};
    endfunction
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= ad;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
        @(posedge i_ref_clk);
        i_reg_addr <= ad;
        i_reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        #1;
        `SMC_CHK("rdata", ex, o_reg_rdata)
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_ref_clk) begin
        if (i_frame_valid && i_nrst) begin
            e_n = model(i_parsers, i_blk0);
            expq.push_back(e_n);
            stat = {e_n[6:2], i_blk0.match, e_n[1:0]};
            n_frm++;
            n_mat += e_n[2];
        end
        if (o_result_valid) begin
            e_q = (expq.size() > 0) ? expq.pop_front() : 7'h7F;
            `SMC_CHK("decision", e_q, {o_stage_out, o_final_match, o_action})
        end
    end
    // A hang is cut short here and counted as a mismatch.
    initial begin
        #200000;
        errors++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        for (int k = 0; k < 4; k++) rd(SMC_STAGE_BASE + 12'(4 * k), SMC_CFG_RESET);
        rd(12'h100, '0);
        for (int r = 0; r < 60; r++) begin
            for (int k = 0; k < 4; k++) begin
                cfg[k] = $random(seed) & 32'h0033_7F0F;
                if (k == 3) cfg[k][21:20] = 2'(r);
                wr(SMC_STAGE_BASE + 12'(4 * k), cfg[k]);
                rd(SMC_STAGE_BASE + 12'(4 * k), cfg[k] & SMC_WMASK[k]);
            end
            en <= 1'b1;
            repeat (20) @(posedge i_ref_clk);
            en <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            rd(SMC_STATUS_ADDR, 32'(stat));
            rd(SMC_COUNT_ADDR, {16'(n_mat), 16'(n_frm)});
            wr(SMC_COUNT_ADDR, 32'h0);
            n_frm = 0;
            n_mat = 0;
        end
        // A reset in mid-run must bring every stage and the status back to zero.
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        cfg = '{default: '0};
        stat = '0;
        for (int k = 0; k < 4; k++) rd(SMC_STAGE_BASE + 12'(4 * k), SMC_CFG_RESET);
        rd(SMC_STATUS_ADDR, 32'h0);
        rd(SMC_COUNT_ADDR, 32'h0);
        `SMC_CHK("pending", 0, expq.size())
        conclude();
    end
endmodule // smc_top_tb
`default_nettype wire
